// ### hw/jsm_lane_mapper.sv
// How it works
// - One mode code sets the whole link
// - 8b/10b multiframe length taken from programmed setting
// - Sixteen lanes, two links, both always driven
// - Lowest lanes powered, data only in modes 5 and 44, zeros in other modes; lanes above the count powered down
// - Link A identifier equals programmed setting
// - Link B identifier is setting plus one
// - Samples are 8-bit octets per mode format
// - Tail bit positions always zero
// - Samples sent MSB first, LSB last
// - Mode 5: even samples A0-3, odd B0-3
// - Mode 44 maps like mode 5
// - Mode 5 multiframe 32 to 256, step 16; other settings still run, only k_legal flags them
// - 64b/66b multiframe fixed by formula
`timescale 1ns/10ps
module jsm_lane_mapper import jsm_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [6:0] link_mode_select,
    input wire logic [7:0] multiframe_length_minus_one,
    input wire logic [7:0] device_id_setting,
    input wire logic sample_valid,
    input wire jsm_frame_t sample_frame,
    output logic sample_ready,
    output logic [JSM_LANES-1:0] link_a_lane_output,
    output logic [JSM_LANES-1:0] link_b_lane_output,
    output logic [JSM_LANES-1:0] link_a_lane_on,
    output logic [JSM_LANES-1:0] link_b_lane_on,
    output jsm_lid_t link_lane_id,
    output jsm_link_id_t link_ids,
    output jsm_mode_t link_cfg,
    output logic mode_fault,
    output logic multiframe_end
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_s_q; // Release shifter
    logic rst_n; // Synchronised reset

    // Two flops on the release edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s_q <= 2'h0;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b1};
        end
    end
    assign rst_n = rst_s_q[1];

    // ----------------------------------------
    // Configuration
    // ----------------------------------------
    jsm_mode_t cfg_new; // Decoded from the live inputs
    jsm_mode_t cfg_q, cfg_d; // Active configuration
    logic [6:0] mode_q, mode_d; // Active mode code
    jsm_link_id_t ids_q, ids_d; // Identifiers of both links
    jsm_state_t st_q, st_d; // Control state

    // Table lookup of the live code
    jsm_mode_decode u_decode (
        .mode(link_mode_select),
        .km1(multiframe_length_minus_one),
        .cfg(cfg_new)
    );

    // Capture in idle, restart on any code change
    always_comb begin
        st_d = st_q;
        cfg_d = cfg_q;
        mode_d = mode_q;
        ids_d = ids_q;
        unique case (st_q)
            // Take the whole setup from the code
            JSM_ST_IDLE: begin
                cfg_d = cfg_new;
                mode_d = link_mode_select;
                ids_d.did_a = device_id_setting;
                ids_d.did_b = device_id_setting + 8'h01;
                st_d = cfg_new.supported ? JSM_ST_RUN : JSM_ST_FAULT;
            end
            // Stream, or hold the fault, until the setup changes
            JSM_ST_RUN, JSM_ST_FAULT: begin
                if (link_mode_select != mode_q
                    || multiframe_length_minus_one != (cfg_q.k_frames[7:0] - 8'h01)
                        && !cfg_q.enc64
                    || device_id_setting != ids_q.did_a) begin
                    st_d = JSM_ST_IDLE;
                end
            end
            // Illegal state encoding
            default: begin
                st_d = JSM_ST_IDLE;
            end
        endcase
    end

    // Register configuration state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= JSM_ST_IDLE;
            cfg_q <= '0;
            mode_q <= 7'h00;
            ids_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
            cfg_q <= cfg_d;
            mode_q <= mode_d;
            ids_q <= ids_d;
        end
    end

    // ----------------------------------------
    // Frame slot timing
    // ----------------------------------------
    logic [2:0] bit_q, bit_d; // Bit slot in the octet
    logic [8:0] fr_q, fr_d; // Frame in the multiframe
    logic mf_q, mf_d; // Multiframe end pulse
    logic slot; // New octet loads now
    logic [8:0] k_last; // Last frame index

    assign k_last = cfg_q.k_frames - 9'h001;
    assign slot = (st_q == JSM_ST_RUN) && (bit_q == JSM_BIT_LAST);
    assign sample_ready = slot;

    // Count bits and frames
    always_comb begin
        bit_d = bit_q;
        fr_d = fr_q;
        mf_d = 1'b0;
        if (st_q != JSM_ST_RUN) begin
            bit_d = JSM_BIT_LAST;
            fr_d = 9'h000;
        end else begin
            bit_d = bit_q + 3'h1;
            if (slot) begin
                // One octet per lane per frame
                mf_d = (fr_q == k_last);
                fr_d = (fr_q == k_last) ? 9'h000 : fr_q + 9'h001;
            end
        end
    end

    // Register slot timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= JSM_BIT_LAST;
            fr_q <= 9'h000;
            mf_q <= 1'b0;
        end else if (clk_en) begin
            bit_q <= bit_d;
            fr_q <= fr_d;
            mf_q <= mf_d;
        end
    end

    // ----------------------------------------
    // Lane power and identifiers
    // ----------------------------------------
    logic [JSM_LANES-1:0] on_q, on_d; // Lanes powered, per link
    jsm_lid_t lid_q, lid_d; // Lane identifiers

    // Low lanes on while streaming, both links alike
    always_comb begin
        on_d = (st_q == JSM_ST_RUN) ? jsm_lane_mask(cfg_q.lanes) : '0;
        for (int i = 0; i < JSM_LANES; i++) begin
            lid_d[i] = jsm_lane_id(i);
        end
    end

    // Register power and identifiers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_q <= '0;
            lid_q <= '0;
        end else if (clk_en) begin
            on_q <= on_d;
            lid_q <= lid_d;
        end
    end

    // ----------------------------------------
    // Sample mapping and serialisers
    // ----------------------------------------
    jsm_octet_t [JSM_LANES-1:0] oct_a; // Octet for each link A lane
    jsm_octet_t [JSM_LANES-1:0] oct_b; // Octet for each link B lane
    logic take; // Frame carries samples

    assign take = slot && sample_valid && cfg_q.direct_map;

    genvar g;
    generate
        for (g = 0; g < JSM_LANES; g++) begin : g_lane
            if (g < JSM_MAP_LANES) begin : g_map
                // Even samples to A, odd samples to B
                assign oct_a[g] = take ? sample_frame[2*g] : '0;
                assign oct_b[g] = take ? sample_frame[2*g+1] : '0;
            end else begin : g_zero
                // No mapping reaches these lanes
                assign oct_a[g] = '0;
                assign oct_b[g] = '0;
            end
            // Link A lane, powered from the next power state so the first slot loads
            jsm_lane_serializer u_ser_a (
                .clk(clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .lane_on(on_d[g]),
                .load(slot),
                .octet(oct_a[g]),
                .ser_bit(link_a_lane_output[g])
            );
            // Link B lane
            jsm_lane_serializer u_ser_b (
                .clk(clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .lane_on(on_d[g]),
                .load(slot),
                .octet(oct_b[g]),
                .ser_bit(link_b_lane_output[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link_a_lane_on = on_q;
    assign link_b_lane_on = on_q;
    assign link_lane_id = lid_q;
    assign link_ids = ids_q;
    assign link_cfg = cfg_q;
    assign mode_fault = (st_q == JSM_ST_FAULT);
    assign multiframe_end = mf_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_ONE_CODE: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN && $past(st_q) == JSM_ST_RUN) |-> $stable(mode_q) && $stable(cfg_q))
        else $error("Configuration changed while streaming");

    AST_K_PROG: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN && !cfg_q.enc64)
            |-> cfg_q.k_frames == {1'b0, $past(multiframe_length_minus_one)} + 9'h001)
        else $error("Multiframe length not from setting");

    AST_BOTH_LINKS: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN) |=> link_a_lane_on[0] && link_b_lane_on[0])
        else $error("A link is not driven");

    AST_LOW_LANES: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN && $past(st_q) == JSM_ST_RUN)
            |-> link_a_lane_on == jsm_lane_mask(cfg_q.lanes) && link_b_lane_on == link_a_lane_on)
        else $error("Lane power does not match mode");

    AST_OFF_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        ((link_a_lane_output & ~link_a_lane_on) == '0) && ((link_b_lane_output & ~link_b_lane_on) == '0))
        else $error("Powered-down lane toggles");

    AST_DID_A: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN) |-> link_ids.did_a == $past(device_id_setting))
        else $error("Link A identifier wrong");

    AST_DID_B: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q != JSM_ST_IDLE) |-> link_ids.did_b == link_ids.did_a + 8'h01)
        else $error("Link B identifier wrong");

    AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
        (take && clk_en && on_q[0]) |=> link_a_lane_output[0] == $past(sample_frame[0][7])
            && link_b_lane_output[0] == $past(sample_frame[1][7]))
        else $error("Sample not sent MSB first");

    AST_EVEN_ODD: assert property (@(posedge clk) disable iff (!rst_n)
        (take && clk_en && on_q[3]) |=> link_a_lane_output[3] == $past(sample_frame[6][7])
            && link_b_lane_output[3] == $past(sample_frame[7][7]))
        else $error("Even/odd lane mapping wrong");

    AST_TAIL_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        (slot && clk_en && !take) |=> link_a_lane_output == '0 && link_b_lane_output == '0)
        else $error("Idle frame not zero");

    AST_MODE44: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN && (mode_q == JSM_MODE_S8L_64 || mode_q == JSM_MODE_S8L)) |-> cfg_q.direct_map)
        else $error("Mode lost its mapping");

    AST_K64: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN && cfg_q.enc64) |-> cfg_q.k_frames == JSM_K_MAX)
        else $error("64b/66b multiframe wrong");

    AST_LID: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == JSM_ST_RUN) |-> link_lane_id[7] == 3'h7 && link_lane_id[2] == 3'h2)
        else $error("Lane identifier wrong");

    COV_MODE5: cover property (@(posedge clk) disable iff (!rst_n)
        take && mode_q == JSM_MODE_S8L);
    COV_MODE44: cover property (@(posedge clk) disable iff (!rst_n)
        take && mode_q == JSM_MODE_S8L_64);
    COV_MF_END: cover property (@(posedge clk) disable iff (!rst_n) multiframe_end);
    COV_FAULT: cover property (@(posedge clk) disable iff (!rst_n) mode_fault);

endmodule

// ### hw/jsm_pkg.sv
package jsm_pkg;

    // ----------------------------------------
    // Link geometry
    // ----------------------------------------
    localparam int JSM_LANES = 8; // Lanes per link
    localparam int JSM_SAMPLES = 8; // Samples per frame slot
    localparam int JSM_MAP_LANES = 4; // Lanes fed by the direct mapping
    localparam logic [2:0] JSM_BIT_LAST = 3'h7; // Last bit of an octet, MSB sent first
    localparam logic [2:0] JSM_BIT_FIRST = 3'h0; // First bit slot of an octet

    // ----------------------------------------
    // Mode codes
    // ----------------------------------------
    localparam logic [6:0] JSM_MODE_S8L = 7'h05; // Single channel, 8 lanes, 8b/10b
    localparam logic [6:0] JSM_MODE_S16L = 7'h06; // Single channel, 16 lanes, 8b/10b
    localparam logic [6:0] JSM_MODE_D8L = 7'h07; // Dual channel, 8 lanes, 8b/10b
    localparam logic [6:0] JSM_MODE_D16L = 7'h08; // Dual channel, 16 lanes, 8b/10b
    localparam logic [6:0] JSM_MODE_S4L_64 = 7'h22; // Single channel, 4 lanes, 64b/66b
    localparam logic [6:0] JSM_MODE_D4L_64 = 7'h23; // Dual channel, 4 lanes, 64b/66b
    localparam logic [6:0] JSM_MODE_S8L_64 = 7'h2C; // Single channel, 8 lanes, 64b/66b
    localparam logic [6:0] JSM_MODE_D8L_64 = 7'h2D; // Dual channel, 8 lanes, 64b/66b
    localparam logic [6:0] JSM_MODE_S16L_64 = 7'h32; // Single channel, 16 lanes, 64b/66b
    localparam logic [6:0] JSM_MODE_D16L_64 = 7'h33; // Dual channel, 16 lanes, 64b/66b

    // ----------------------------------------
    // Multiframe length
    // ----------------------------------------
    localparam logic [8:0] JSM_K_MIN = 9'h020; // Least frames per multiframe
    localparam logic [8:0] JSM_K_MAX = 9'h100; // Most frames per multiframe
    localparam logic [3:0] JSM_K_STEP_MASK = 4'hF; // Step of 16 frames
    localparam int JSM_K64_OCTETS = 256; // Octets per extended multiblock unit
    localparam int JSM_EMB = 1; // Extended multiblocks per multiframe
    localparam int JSM_F = 1; // Octets per frame, every mode
    localparam logic [3:0] JSM_L4 = 4'h4; // Four lanes per link
    localparam logic [3:0] JSM_L8 = 4'h8; // Eight lanes per link
    localparam logic [3:0] JSM_L2 = 4'h2; // Two lanes per link

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef logic [7:0] jsm_octet_t; // One offset-binary sample
    typedef jsm_octet_t [JSM_SAMPLES-1:0] jsm_frame_t; // Samples of one frame slot
    typedef logic [JSM_LANES-1:0][2:0] jsm_lid_t; // Lane identifier per lane

    typedef struct packed {
        logic supported; // Code is a listed mode
        logic enc64; // 64b/66b encoding
        logic direct_map; // Even/odd split mapping applies
        logic [3:0] lanes; // Lanes used per link
        logic [8:0] k_frames; // Frames per multiframe
        logic k_legal; // Multiframe setting within range and step
    } jsm_mode_t;

    typedef struct packed {
        logic [7:0] did_a; // Device identifier of link A
        logic [7:0] did_b; // Device identifier of link B
    } jsm_link_id_t;

    typedef enum logic [1:0] {
        JSM_ST_IDLE = 2'b00, // Capturing configuration
        JSM_ST_RUN = 2'b01, // Streaming frames
        JSM_ST_FAULT = 2'b10 // Unlisted mode code
    } jsm_state_t;

    // Lane mask for the lowest n lanes
    function automatic logic [JSM_LANES-1:0] jsm_lane_mask(input logic [3:0] n);
        logic [JSM_LANES-1:0] m;
        m = '0;
        for (int i = 0; i < JSM_LANES; i++) begin
            m[i] = (4'(i) < n);
        end
        return m;
    endfunction

    // Lane identifier from physical index
    function automatic logic [2:0] jsm_lane_id(input int idx);
        return 3'(idx);
    endfunction

endpackage

// ### hw/jsm_mode_decode.sv
`timescale 1ns/10ps
module jsm_mode_decode import jsm_pkg::*; (
    input wire logic [6:0] mode,
    input wire logic [7:0] km1,
    output jsm_mode_t cfg
);

    // ----------------------------------------
    // Mode table
    // ----------------------------------------

    // Multiframe length from the programmed setting
    logic [8:0] k_prog;
    assign k_prog = {1'b0, km1} + 9'h001;

    // Whole configuration from one code
    always_comb begin
        cfg = '0;
        unique case (mode)
            // 8b/10b modes with programmable multiframe
            JSM_MODE_S8L, JSM_MODE_D8L: begin
                cfg.lanes = JSM_L4;
            end
            JSM_MODE_S16L, JSM_MODE_D16L: begin
                cfg.lanes = JSM_L8;
            end
            // 64b/66b modes
            JSM_MODE_S4L_64, JSM_MODE_D4L_64: begin
                cfg.lanes = JSM_L2;
                cfg.enc64 = 1'b1;
            end
            JSM_MODE_S8L_64, JSM_MODE_D8L_64: begin
                cfg.lanes = JSM_L4;
                cfg.enc64 = 1'b1;
            end
            JSM_MODE_S16L_64, JSM_MODE_D16L_64: begin
                cfg.lanes = JSM_L8;
                cfg.enc64 = 1'b1;
            end
            // Reserved code
            default: begin
                cfg.lanes = 4'h0;
            end
        endcase
        cfg.supported = (cfg.lanes != 4'h0);
        cfg.direct_map = (mode == JSM_MODE_S8L) || (mode == JSM_MODE_S8L_64);
        if (cfg.enc64) begin
            cfg.k_frames = 9'(JSM_K64_OCTETS * JSM_EMB / JSM_F);
            cfg.k_legal = 1'b1;
        end else begin
            cfg.k_frames = k_prog;
            cfg.k_legal = (k_prog >= JSM_K_MIN) && (k_prog <= JSM_K_MAX)
                && ((k_prog[3:0] & JSM_K_STEP_MASK) == 4'h0);
        end
    end

endmodule

// ### hw/jsm_lane_serializer.sv
`timescale 1ns/10ps
module jsm_lane_serializer import jsm_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic lane_on,
    input wire logic load,
    input wire jsm_octet_t octet,
    output logic ser_bit
);

    // ----------------------------------------
    // Shift register
    // ----------------------------------------
    jsm_octet_t sh_q; // Octet being sent
    jsm_octet_t sh_d; // Next contents

    // Load, shift left with zero fill, or stay quiet when off
    always_comb begin
        sh_d = sh_q;
        if (!lane_on) begin
            sh_d = '0;
        end else if (load) begin
            sh_d = octet;
        end else begin
            sh_d = {sh_q[6:0], 1'b0};
        end
    end

    // Register the shift state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= '0;
        end else if (clk_en) begin
            sh_q <= sh_d;
        end
    end

    // Most significant bit leaves first
    assign ser_bit = sh_q[7];

endmodule

// ### verif/jsm_rx_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Receiver model: deserialises both links
// ----------------------------------------
module jsm_rx_model import jsm_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slot,
    input wire logic [JSM_LANES-1:0] lane_a,
    input wire logic [JSM_LANES-1:0] lane_b,
    output jsm_frame_t rx_a,
    output jsm_frame_t rx_b,
    output logic rx_done
);
    logic [3:0] ph_q; // Bit position in the octet, 0 when idle

    // First bit after a slot lands in the MSB; done pulses with a whole octet
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 4'h0;
            rx_a <= '0;
            rx_b <= '0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= (ph_q == 4'h8);
            if (ph_q != 4'h0) begin
                for (int i = 0; i < JSM_LANES; i++) begin
                    rx_a[i] <= {rx_a[i][6:0], lane_a[i]};
                    rx_b[i] <= {rx_b[i][6:0], lane_b[i]};
                end
            end
            // One octet per lane per frame, back to back allowed
            if (ph_q == 4'h8 || ph_q == 4'h0) begin
                ph_q <= {3'h0, slot};
            end else begin
                ph_q <= ph_q + 4'h1;
            end
        end
    end
endmodule

// ### verif/test_jsm_lane_sample_mapper.sv
`timescale 1ns/10ps
module test_jsm_lane_sample_mapper import jsm_pkg::*; ();
    // ----------------------------------------
    // Signals and bench state
    // ----------------------------------------
    logic clk, nrst, sample_valid, sample_ready, mode_fault, multiframe_end, rx_done, flush, drive_on, cur_map;
    logic [6:0] link_mode_select;
    logic [7:0] multiframe_length_minus_one, device_id_setting;
    logic [JSM_LANES-1:0] link_a_lane_output, link_b_lane_output, link_a_lane_on, link_b_lane_on;
    jsm_frame_t sample_frame, rx_a, rx_b;
    jsm_lid_t link_lane_id;
    jsm_link_id_t link_ids;
    jsm_mode_t link_cfg;
    int err_count, n_compared, nfr;
    logic [31:0] seed;
    jsm_frame_t qa[$], qb[$]; // Expected octets per link
    logic [6:0] codes [0:9] = '{7'h05, 7'h06, 7'h07, 7'h08, 7'h22, 7'h23, 7'h2C, 7'h2D, 7'h32, 7'h33};
    logic [6:0] bad [0:5] = '{7'h00, 7'h04, 7'h09, 7'h24, 7'h34, 7'h7F}; // Unlisted codes

    jsm_lane_mapper i_jsm_lane_mapper (
        .clk(clk), .nrst(nrst), .clk_en(1'b1), .link_mode_select(link_mode_select),
        .multiframe_length_minus_one(multiframe_length_minus_one), .device_id_setting(device_id_setting),
        .sample_valid(sample_valid), .sample_frame(sample_frame), .sample_ready(sample_ready),
        .link_a_lane_output(link_a_lane_output), .link_b_lane_output(link_b_lane_output),
        .link_a_lane_on(link_a_lane_on), .link_b_lane_on(link_b_lane_on), .link_lane_id(link_lane_id),
        .link_ids(link_ids), .link_cfg(link_cfg), .mode_fault(mode_fault), .multiframe_end(multiframe_end));

    jsm_rx_model i_jsm_rx_model (
        .clk(clk), .rst_n(nrst && !flush), .slot(sample_ready), .lane_a(link_a_lane_output),
        .lane_b(link_b_lane_output), .rx_a(rx_a), .rx_b(rx_b), .rx_done(rx_done));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Lanes per link, 0 for unlisted codes
    function automatic logic [3:0] exp_lanes(input logic [6:0] m);
        case (m)
            7'h05, 7'h07, 7'h2C, 7'h2D: return 4'h4;
            7'h06, 7'h08, 7'h32, 7'h33: return 4'h8;
            7'h22, 7'h23: return 4'h2;
            default: return 4'h0;
        endcase
    endfunction

    // Octets of one link: even or odd samples on the low four lanes
    function automatic jsm_frame_t exp_link(input jsm_frame_t s, input logic ok, input int odd);
        jsm_frame_t o;
        o = '0;
        for (int i = 0; i < 4; i++) begin
            if (ok) o[i] = s[2*i+odd];
        end
        return o;
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Apply a configuration, wait for capture, check what it derives
    task automatic set_cfg(input logic [6:0] m, input logic [7:0] k, input logic [7:0] d);
        logic [3:0] l;
        logic [8:0] kx;
        logic [7:0] msk;
        int i;
        l = exp_lanes(m);
        kx = (m >= 7'h22) ? 9'h100 : {1'b0, k} + 9'h001;
        msk = 8'((16'h1 << l) - 16'h1);
        @(negedge clk);
        flush = 1'b1;
        @(posedge clk);
        link_mode_select <= m;
        multiframe_length_minus_one <= k;
        device_id_setting <= d;
        qa.delete();
        qb.delete();
        cur_map = (m == 7'h05 || m == 7'h2C);
        repeat (2) @(posedge clk);
        for (i = 0; i < 30; i++) begin
            @(negedge clk);
            if (sample_ready === 1'b1 || mode_fault === 1'b1) break;
        end
        if (i == 30) begin
            check(64'h0, 64'h1);
            complete_run();
        end
        flush = 1'b0;
        @(negedge clk);
        check(mode_fault, l == 4'h0);
        check(link_a_lane_on, msk);
        check(link_b_lane_on, msk);
        check(link_lane_id, 24'hFAC688);
        if (l != 4'h0) begin
            check(link_cfg.lanes, l);
            check(link_cfg.enc64, m >= 7'h22);
            check(link_cfg.k_frames, kx);
            if (m < 7'h22) check(link_cfg.k_legal, kx >= 9'h020 && kx[3:0] == 4'h0);
            check(link_ids.did_a, d);
            check(link_ids.did_b, 8'(d + 8'h01));
            check(link_cfg.direct_map, m == 7'h05 || m == 7'h2C);
        end
    endtask

    task automatic wait_frames(input int n);
        int t;
        t = nfr + n;
        for (int i = 0; i < n * 8 + 40 && nfr < t; i++) @(negedge clk);
        check(nfr >= t, 1'b1);
    endtask

    // Slots counted between two multiframe end pulses
    task automatic mf_check(input int k);
        int c;
        int i;
        c = 0;
        for (i = 0; i < k * 8 + 40; i++) begin
            @(negedge clk);
            if (multiframe_end === 1'b1) break;
        end
        for (i = 0; i < k * 8 + 40; i++) begin
            @(negedge clk);
            if (sample_ready === 1'b1) c++;
            if (multiframe_end === 1'b1) break;
        end
        check(c, k);
    endtask

    // ----------------------------------------
    // Clock, stimulus and monitors
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Random frames every cycle, valid unless three random bits are all zero
    always @(posedge clk) begin
        if (drive_on) begin
            sample_frame <= {xs(), xs()};
            sample_valid <= (xs() & 32'h7) != 32'h0;
        end
    end

    // Record what each slot, taken or not, should put on the lanes
    always @(posedge clk) begin
        if (!flush && nrst && sample_ready === 1'b1) begin
            qa.push_back(exp_link(sample_frame, sample_valid && cur_map, 0));
            qb.push_back(exp_link(sample_frame, sample_valid && cur_map, 1));
        end
    end

    // Compare each received octet set against the oldest expectation
    always @(negedge clk) begin
        if (rx_done === 1'b1) begin
            if (qa.size() == 0) begin
                check(64'h0, 64'h1);
            end else begin
                check(rx_a, qa.pop_front());
                check(rx_b, qb.pop_front());
                nfr++;
            end
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'd91003;
        err_count = 0;
        n_compared = 0;
        nfr = 0;
        nrst = 1'b0;
        flush = 1'b1;
        drive_on = 1'b0;
        cur_map = 1'b0;
        link_mode_select = 7'h05;
        multiframe_length_minus_one = 8'h1F;
        device_id_setting = 8'h00;
        sample_valid = 1'b0;
        sample_frame = '0;
        repeat (12) @(posedge clk);
        check(link_a_lane_on, 8'h00);
        check(sample_ready, 1'b0);
        nrst <= 1'b1;
        drive_on <= 1'b1;
        set_cfg(7'h05, 8'h1F, 8'h10);
        wait_frames(40);
        mf_check(32);
        set_cfg(7'h05, 8'h20, 8'h3C);
        wait_frames(10);
        mf_check(33);
        set_cfg(7'h2C, 8'h00, 8'hFF);
        wait_frames(40);
        mf_check(256);
        for (int j = 0; j < 10; j++) begin
            set_cfg(codes[j], 8'((xs() % 15 + 1) * 16 + 15), 8'(xs()));
            wait_frames(4);
        end
        for (int j = 0; j < 6; j++) set_cfg(bad[j], 8'h1F, 8'h01);
        set_cfg(7'h05, 8'hFF, 8'h7E);
        wait_frames(8);
        complete_run();
    end
endmodule
